// ---- hw/six_channel_shared_period_pwm.sv ----
// Six-channel PWM with one shared 8-bit counter and AXI4-Lite registers.
// Assumes bus and pins on clk; pin muxing to other functions lies outside.
//
// How it works
// - Enable bit lets the counter run
// - Disabled: stop and hold counter at zero
// - Counter passing period sets overflow flag
// - Interrupt while flag and enable set
// - Channels 0-2 driven only when routed
// - Channels 3-5 driven only when routed
// - Select picks divide by 1, 2, 4, 8, 32, 64, 128 or 256
// - Counter at period returns to zero
// - Period is period value plus one
// - Channels 0-2 inverted by their bits
// - Channels 3-5 inverted by their bits
// - High time equals duty setting
// - Duty and period writes act immediately
// - Unrouted but enabled still counts, interrupts
`timescale 1ns/1ns
`default_nettype none

module six_channel_shared_period_pwm
   import pwm_pkg::*;
#(
   parameter logic [7:0] DIV_SEL7_LAST = DIV_LAST_256
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Channel pins and interrupt
   output pwm_pins_s pins,
   output logic irq
);

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------

   // Map a byte address to a register select code
   function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
      logic [9:0] idx;
      logic [3:0] r;
      idx = a[ADDR_W-1:2];
      r = SEL_NONE;
      case (idx)
         IDX_CFG_A: r = SEL_CFG_A;
         IDX_CTRL: r = SEL_CTRL;
         IDX_PRD: r = SEL_PRD;
         IDX_CFG_B: r = SEL_CFG_B;
         IDX_IRQ_STAT: r = SEL_STAT;
         IDX_IRQ_MASK: r = SEL_MASK;
         default: r = SEL_NONE;
      endcase
      for (int i = 0; i < CHANS; i++)
      begin
         if (idx == IDX_DUTY[i])
         begin
            r = SEL_DUTY0 + 4'(i);
         end
      end
      return r;
   endfunction

   // Prescaler terminal count for a divider select
   function automatic logic [7:0] div_last(input logic [SEL_W-1:0] sel);
      logic [7:0] d;
      case (sel)
         3'h0: d = DIV_LAST_1;
         3'h1: d = DIV_LAST_2;
         3'h2: d = DIV_LAST_4;
         3'h3: d = DIV_LAST_8;
         3'h4: d = DIV_LAST_32;
         3'h5: d = DIV_LAST_64;
         3'h6: d = DIV_LAST_128;
         default: d = DIV_SEL7_LAST;
      endcase
      return d;
   endfunction

   // ------------------------------------------------------------
   // State and derived terms
   // ------------------------------------------------------------
   pwm_state_s s;        // Registered state
   pwm_state_s next_s;   // Next state
   logic on;             // Unit running
   logic tick;           // Count clock tick
   logic wrap;           // Counter passes the period
   logic do_wr;          // Register write this cycle
   logic [3:0] wsel;     // Write target
   logic [3:0] rsel;     // Read target
   logic [5:0] route;    // Per-channel pin routing
   logic [5:0] inv;      // Per-channel inversion
   logic [SEL_W-1:0] csel;

   assign on = s.ctrl[CTRL_ON_BIT];
   assign csel = s.ctrl[CTRL_SEL_LSB +: SEL_W];
   // At or past the terminal count, so a switch to a faster divider ticks at once
   assign tick = on && (s.pre >= div_last(csel));
   assign wrap = tick && (s.cnt >= s.prd);
   assign do_wr = s.aw_full && s.w_full && !s.bvalid;
   assign wsel = reg_sel(s.awaddr);
   assign rsel = reg_sel(s_axi_araddr);
   assign route = {s.cfg_a[CFGA_ROUTE_LSB +: 3], s.ctrl[CTRL_ROUTE_LSB +: 3]};
   assign inv = {s.cfg_b[CFGB_INV_LSB +: 3], s.cfg_a[CFGA_INV_LSB +: 3]};

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready = !s.aw_full;
   assign s_axi_wready = !s.w_full;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = {24'h000000, s.rdata};
   assign s_axi_rresp = s.rresp;
   assign pins.out = s.pin;
   assign pins.oe = route;
   // Flag or logged event, gated by the enable
   assign irq = s.irq_mask[IRQ_OVF_BIT] && (s.ctrl[CTRL_FLAG_BIT] || s.irq_stat[IRQ_OVF_BIT]);

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      // Write address and data taken in any order
      if (s_axi_awvalid && !s.aw_full)
      begin
         next_s.aw_full = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.w_full)
      begin
         next_s.w_full = 1'b1;
         next_s.wdata = s_axi_wdata[7:0];
         next_s.wlane = s_axi_wstrb[0];
      end
      // Response handed over
      if (s.bvalid && s_axi_bready)
      begin
         next_s.bvalid = 1'b0;
      end
      // Register write once both halves are held
      if (do_wr)
      begin
         next_s.aw_full = 1'b0;
         next_s.w_full = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         if (s.wlane)
         begin
            case (wsel)
               SEL_CFG_A: next_s.cfg_a = s.wdata;
               SEL_CTRL: next_s.ctrl = s.wdata;
               SEL_PRD: next_s.prd = s.wdata;
               SEL_CFG_B: next_s.cfg_b = s.wdata & CFGB_MASK;
               SEL_MASK: next_s.irq_mask = s.wdata;
               default:
               begin
                  if (wsel >= SEL_DUTY0)
                  begin
                     next_s.duty[wsel - SEL_DUTY0] = s.wdata;
                  end
               end
            endcase
         end
      end
      // Read data handed over
      if (s.rvalid && s_axi_rready)
      begin
         next_s.rvalid = 1'b0;
      end
      // Read taken, status cleared by its read
      if (s_axi_arvalid && !s.rvalid)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         case (rsel)
            SEL_CFG_A: next_s.rdata = s.cfg_a;
            SEL_CTRL: next_s.rdata = s.ctrl;
            SEL_PRD: next_s.rdata = s.prd;
            SEL_CFG_B: next_s.rdata = s.cfg_b;
            SEL_STAT:
            begin
               next_s.rdata = s.irq_stat;
               next_s.irq_stat = 8'h00;
            end
            SEL_MASK: next_s.rdata = s.irq_mask;
            default:
            begin
               next_s.rdata = 8'h00;
               if (rsel >= SEL_DUTY0)
               begin
                  next_s.rdata = s.duty[rsel - SEL_DUTY0];
               end
            end
         endcase
      end
      // Prescaler and shared counter
      if (!on)
      begin
         next_s.pre = 8'h00;
         next_s.cnt = 8'h00;
      end
      else
      begin
         next_s.pre = tick ? 8'h00 : s.pre + 8'h01;
         if (wrap)
         begin
            next_s.cnt = 8'h00;
         end
         else if (tick)
         begin
            next_s.cnt = s.cnt + 8'h01;
         end
      end
      // Overflow sets flag and status, winning over any clear
      if (wrap)
      begin
         next_s.ctrl[CTRL_FLAG_BIT] = 1'b1;
         next_s.irq_stat[IRQ_OVF_BIT] = 1'b1;
      end
      // Compare and invert each channel
      for (int i = 0; i < CHANS; i++)
      begin
         next_s.pin[i] = (s.cnt < s.duty[i]) ^ inv[i];
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   AST_STOP_HOLD: assert property (!on |=> s.cnt == 8'h00)
      else $error("counter not held at zero while stopped");

   AST_RUN: assert property (on && tick && !wrap |=> s.cnt == $past(s.cnt) + 8'h01)
      else $error("counter did not advance on tick");

   AST_WRAP_ZERO: assert property (wrap |=> s.cnt == 8'h00)
      else $error("counter did not return to zero");

   AST_FLAG_SET: assert property (wrap |=> s.ctrl[CTRL_FLAG_BIT])
      else $error("overflow did not set the flag");

   AST_FLAG_KEEP: assert property (s.ctrl[CTRL_FLAG_BIT] && !do_wr |=> s.ctrl[CTRL_FLAG_BIT])
      else $error("flag dropped without a write");

   AST_IRQ: assert property (s.ctrl[CTRL_FLAG_BIT] && s.irq_mask[IRQ_OVF_BIT] |-> irq)
      else $error("interrupt missing with flag and enable");

   AST_DIV_ONE: assert property (on && csel == 3'h0 |-> tick)
      else $error("divide by one missed a tick");

   AST_DIV_TWO: assert property (tick && csel == 3'h1 ##1 on && csel == 3'h1 |-> !tick)
      else $error("divide by two ticked twice in a row");

   AST_PERIOD: assert property (tick && (s.cnt < s.prd) |=> s.cnt == $past(s.cnt) + 8'h01)
      else $error("period shorter than value plus one");

   AST_ROUTE_A: assert property (pins.oe[2:0] == s.ctrl[CTRL_ROUTE_LSB +: 3])
      else $error("channels 0-2 drive enable wrong");

   AST_ROUTE_B: assert property (pins.oe[5:3] == s.cfg_a[CFGA_ROUTE_LSB +: 3])
      else $error("channels 3-5 drive enable wrong");

   AST_INV_A: assert property (1'b1 |=> pins.out[0] == (($past(s.cnt) < $past(s.duty[0])) ^ $past(inv[0])))
      else $error("channel 0 level wrong");

   AST_INV_B: assert property (1'b1 |=> pins.out[5] == (($past(s.cnt) < $past(s.duty[5])) ^ $past(inv[5])))
      else $error("channel 5 level wrong");

   AST_RESET: assert property ($fell(reset) |-> s.ctrl == 8'h00 && s.prd == 8'h00 && pins.oe == 6'h00)
      else $error("unit not cleared by reset");

   AST_PRE_HOLD: assert property (!on |=> s.pre == 8'h00)
      else $error("prescaler not held at zero while stopped");

   AST_STAT_SET: assert property (wrap |=> s.irq_stat[IRQ_OVF_BIT])
      else $error("overflow did not log the status bit");

   AST_IRQ_LOW: assert property (!s.irq_mask[IRQ_OVF_BIT] |-> !irq)
      else $error("interrupt raised while disabled");

   AST_FLAG_CLEAR: assert property (do_wr && s.wlane && wsel == SEL_CTRL && !s.wdata[CTRL_FLAG_BIT] && !wrap |=> !s.ctrl[CTRL_FLAG_BIT])
      else $error("flag not cleared by a zero write");

   AST_PRD_NOW: assert property (do_wr && s.wlane && wsel == SEL_PRD |=> s.prd == $past(s.wdata))
      else $error("period write did not act at once");

   AST_DUTY_NOW: assert property (do_wr && s.wlane && wsel == SEL_DUTY0 |=> s.duty[0] == $past(s.wdata))
      else $error("duty write did not act at once");

endmodule

`default_nettype wire

// ---- hw/pwm_pkg.sv ----
// Shared constants and types of the six-channel PWM unit.
// Assumes a single 50 MHz clock domain and an AXI4-Lite register bus.
package pwm_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int CHANS = 6;           // Output channels
   localparam int DATA_W = 8;          // Register and counter width
   localparam int ADDR_W = 12;         // Byte address width on the bus

   // ------------------------------------------------------------
   // Register indexes, byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_CFG_A = 10'h0d1;
   localparam logic [9:0] IDX_CTRL = 10'h0d2;
   localparam logic [9:0] IDX_PRD = 10'h0d3;
   localparam logic [9:0] IDX_CFG_B = 10'h0d4;
   localparam logic [9:0] IDX_IRQ_STAT = 10'h0e0;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h0e1;
   localparam logic [5:0][9:0] IDX_DUTY = {10'h0df, 10'h0de, 10'h0dd, 10'h0d7, 10'h0d6, 10'h0d5};

   // ------------------------------------------------------------
   // Register select codes from the address decoder
   // ------------------------------------------------------------
   localparam logic [3:0] SEL_NONE = 4'h0;
   localparam logic [3:0] SEL_CFG_A = 4'h1;
   localparam logic [3:0] SEL_CTRL = 4'h2;
   localparam logic [3:0] SEL_PRD = 4'h3;
   localparam logic [3:0] SEL_CFG_B = 4'h4;
   localparam logic [3:0] SEL_STAT = 4'h5;
   localparam logic [3:0] SEL_MASK = 4'h6;
   localparam logic [3:0] SEL_DUTY0 = 4'h8;   // Duty n is SEL_DUTY0 + n

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_ON_BIT = 7;     // module_on
   localparam int CTRL_FLAG_BIT = 6;   // period_overflow_flag
   localparam int CTRL_ROUTE_LSB = 3;  // chan0..2_pin_route
   localparam int CTRL_SEL_LSB = 0;    // count_clock_divider_select
   localparam int SEL_W = 3;
   localparam int CFGA_ROUTE_LSB = 0;  // chan3..5_pin_route
   localparam int CFGA_INV_LSB = 3;    // chan0..2_invert
   localparam int CFGB_INV_LSB = 3;    // chan3..5_invert
   localparam logic [7:0] CFGB_MASK = 8'h38;
   localparam int IRQ_OVF_BIT = 1;     // overflow_irq_enable position

   // ------------------------------------------------------------
   // Prescaler terminal counts (divide minus one)
   // ------------------------------------------------------------
   localparam logic [7:0] DIV_LAST_1 = 8'h00;
   localparam logic [7:0] DIV_LAST_2 = 8'h01;
   localparam logic [7:0] DIV_LAST_4 = 8'h03;
   localparam logic [7:0] DIV_LAST_8 = 8'h07;
   localparam logic [7:0] DIV_LAST_32 = 8'h1f;
   localparam logic [7:0] DIV_LAST_64 = 8'h3f;
   localparam logic [7:0] DIV_LAST_128 = 8'h7f;
   localparam logic [7:0] DIV_LAST_256 = 8'hff;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   // Pin group of all channels
   typedef struct packed {
      logic [5:0] out;   // Pin level
      logic [5:0] oe;    // Drive enable
   } pwm_pins_s;

   // Whole state of the unit
   typedef struct packed {
      logic [7:0] cfg_a;
      logic [7:0] ctrl;
      logic [7:0] prd;
      logic [7:0] cfg_b;
      logic [5:0][7:0] duty;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      logic [7:0] pre;
      logic [7:0] cnt;
      logic [5:0] pin;
      logic aw_full;
      logic [ADDR_W-1:0] awaddr;
      logic w_full;
      logic [7:0] wdata;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } pwm_state_s;

endpackage

// ---- tb/pin_load.sv ----
// Load model hanging on the six channel pins.
// Assumes a pull-down on every pin while the unit does not drive it.
`timescale 1ns/1ns
`default_nettype none

module pin_load
   import pwm_pkg::*;
(
   // Pins from the unit
   input wire pwm_pins_s pins,
   // Level seen at each pin
   output logic [5:0] level
);
   // Released pins fall to the pull-down level
   always_comb
   begin
      for (int i = 0; i < 6; i++)
         level[i] = pins.oe[i] ? pins.out[i] : 1'b0;
   end
endmodule

`default_nettype wire

// ---- tb/test_six_channel_shared_period_pwm.sv ----
// Self-checking bench of the six-channel PWM unit.
// Assumes pwm_pkg, the unit and pin_load are compiled first.
`timescale 1ns/1ns
`default_nettype none

module test_six_channel_shared_period_pwm
   import pwm_pkg::*;
;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk = 0;
   logic reset = 1;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   pwm_pins_s pins;
   logic [5:0] level; // Pin levels after the load
   int fails = 0;
   int samples_checked = 0;

   // Unit under test, protection and strobes tied
   six_channel_shared_period_pwm u_dut
   (
      .clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .pins, .irq
   );

   // External loads on the pins
   pin_load u_load
   (
      .pins, .level
   );

   // 50 MHz clock
   initial
   begin
      forever #10 clk = ~clk;
   end

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic conclude;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A wait ran out
   task automatic hang;
      fails++;
      conclude();
   endtask

   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   // One write, both channels offered together
   task automatic wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] resp);
      logic aw_open;
      logic w_open;
      aw_open = 1;
      w_open = 1;
      @(posedge clk);
      s_axi_awvalid <= 1;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wvalid <= 1;
      s_axi_wdata <= {24'h0, d};
      s_axi_bready <= 1;
      for (int n = 0; n < 20; n++)
      begin
         @(posedge clk);
         // Release each channel once taken
         if (aw_open && s_axi_awready)
         begin
            aw_open = 0;
            s_axi_awvalid <= 0;
         end
         if (w_open && s_axi_wready)
         begin
            w_open = 0;
            s_axi_wvalid <= 0;
         end
         if (s_axi_bvalid)
         begin
            resp = s_axi_bresp;
            s_axi_bready <= 0;
            return;
         end
      end
      hang();
   endtask

   // One read
   task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] resp);
      @(posedge clk);
      s_axi_arvalid <= 1;
      s_axi_araddr <= {idx, 2'b00};
      s_axi_rready <= 1;
      for (int n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 0;
         if (s_axi_rvalid)
         begin
            d = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 0;
            return;
         end
      end
      hang();
   endtask

   // Write expecting an okay answer
   task automatic put(input logic [9:0] idx, input logic [7:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      chk(r, RESP_OKAY);
   endtask

   // Read and compare
   task automatic expect_reg(input logic [9:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      chk(r, RESP_OKAY);
      chk(d, exp);
   endtask

   // Count high cycles of one pin
   task automatic hi_count(input int ch, input int cycles, input int exp);
      logic [31:0] n;
      n = '0;
      repeat (cycles)
      begin
         @(posedge clk);
         n += level[ch];
      end
      chk(n, exp);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk(pins.oe, 6'h00);
      chk(irq, 1'b0);
      expect_reg(IDX_CTRL, 32'h0);
      expect_reg(IDX_CFG_A, 32'h0);
      expect_reg(IDX_PRD, 32'h0);
      expect_reg(IDX_CFG_B, 32'h0);
   endtask

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      put(IDX_CFG_B, 8'hff);
      expect_reg(IDX_CFG_B, 32'h38);
      put(IDX_PRD, 8'ha5);
      expect_reg(IDX_PRD, 32'ha5);
      wr(10'h000, 8'h55, r);
      chk(r, RESP_SLVERR);
      rd(10'h000, d, r);
      chk(r, RESP_SLVERR);
      put(IDX_CFG_B, 8'h00);
   endtask

   task automatic t_route;
      put(IDX_CTRL, 8'h38);
      put(IDX_CFG_A, 8'h07);
      chk(pins.oe, 6'h3f);
      put(IDX_CTRL, 8'h08);
      put(IDX_CFG_A, 8'h04);
      chk(pins.oe, 6'h21);
   endtask

   // Every divider code, two-cycle period, one high
   task automatic t_div;
      int dv[8] = '{1, 2, 4, 8, 32, 64, 128, 256};
      put(IDX_PRD, 8'h01);
      put(IDX_DUTY[0], 8'h01);
      for (int s = 0; s < 8; s++)
      begin
         put(IDX_CTRL, {5'b10001, s[2:0]});
         repeat (2 * dv[s]) @(posedge clk);
         hi_count(0, 4 * dv[s], 2 * dv[s]);
      end
   endtask

   // Inversion and a duty change in mid-run
   task automatic t_inv;
      put(IDX_PRD, 8'h04);
      put(IDX_DUTY[0], 8'h02);
      put(IDX_DUTY[3], 8'h02);
      put(IDX_CFG_A, 8'h09);
      put(IDX_CFG_B, 8'h08);
      put(IDX_CTRL, 8'h88);
      repeat (5) @(posedge clk);
      hi_count(0, 10, 6);
      hi_count(3, 10, 6);
      put(IDX_DUTY[0], 8'h04);
      hi_count(0, 10, 2);
   endtask

   // Overflow flag, mask, sticky flag, stop
   task automatic t_irq;
      logic [31:0] d;
      logic [1:0] r;
      put(IDX_CFG_A, 8'h00);
      // Stop, clear old flag and status so only unrouted counting can set them
      put(IDX_CTRL, 8'h00);
      put(IDX_CTRL, 8'h00);
      rd(IDX_IRQ_STAT, d, r);
      put(IDX_CTRL, 8'h80);
      repeat (12) @(posedge clk);
      chk(irq, 1'b0);
      chk(pins.oe, 6'h00);
      put(IDX_IRQ_MASK, 8'h02);
      chk(irq, 1'b1);
      expect_reg(IDX_IRQ_STAT, 32'h02);
      rd(IDX_CTRL, d, r);
      chk(d[6], 1'b1);
      put(IDX_CTRL, 8'h08);
      put(IDX_CTRL, 8'h08);
      rd(IDX_IRQ_STAT, d, r);
      repeat (12) @(posedge clk);
      expect_reg(IDX_CTRL, 32'h08);
      chk(irq, 1'b0);
      hi_count(0, 20, 20);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge clk);
      reset <= 0;
      t_reset();
      t_regs();
      t_route();
      t_div();
      t_inv();
      t_irq();
      conclude();
   end
endmodule

`default_nettype wire
